// ### inc/acrb_pkg.sv
// Package: register map, field layout, reset values and codes
`default_nettype none
package acrb_pkg;
   // ********************************************
   // Register offsets
   // ********************************************
   localparam logic [7:0] ADDR_RATE_BIN = 8'h02;
   localparam logic [7:0] ADDR_POWER = 8'h08;
   localparam logic [7:0] ADDR_STAB = 8'h09;
   localparam logic [7:0] ADDR_CLKDIV = 8'h0B;
   localparam logic [7:0] ADDR_TEST = 8'h0D;
   localparam logic [7:0] ADDR_OFFSET = 8'h10;
   localparam logic [7:0] ADDR_COMMIT = 8'hFF;
   // ********************************************
   // Reset values and field layout
   // ********************************************
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_STAB = 8'h01;
   localparam logic [7:0] RST_CLKDIV = 8'h00;
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] COMMIT_VALUE = 8'h01;
   localparam int TEST_SINGLE_BIT = 7;
   localparam int LONG_RESTART_BIT = 5;
   localparam int SHORT_RESTART_BIT = 4;
   localparam int RATE_BIN_LSB = 4;
   localparam int OUT_W = 11;
   localparam int PAT_W = 16;
   // Identification value: arbitrary neutral choice
   localparam logic [1:0] RATE_BIN_DEFAULT = 2'h1;
   localparam logic [22:0] LONG_SEED = 23'h7FFFFF;
   localparam logic [8:0] SHORT_SEED = 9'h1FF;
   localparam logic [10:0] MIDSCALE = 11'h000;
   localparam logic [10:0] POS_FS = 11'h3FF;
   localparam logic [10:0] NEG_FS = 11'h400;
   localparam logic [10:0] CHECKER = 11'h555;
   // ********************************************
   // Modes
   // ********************************************
   typedef enum logic [1:0] {
      ACRB_PWR_NORMAL = 2'b00,
      ACRB_PWR_DOWN = 2'b01,
      ACRB_PWR_STANDBY = 2'b10,
      ACRB_PWR_RSVD = 2'b11
   } acrb_power_t;
   typedef enum logic [3:0] {
      ACRB_TM_OFF = 4'b0000,
      ACRB_TM_MID = 4'b0001,
      ACRB_TM_POS = 4'b0010,
      ACRB_TM_NEG = 4'b0011,
      ACRB_TM_CHECK = 4'b0100,
      ACRB_TM_PNL = 4'b0101,
      ACRB_TM_PNS = 4'b0110,
      ACRB_TM_TOGGLE = 4'b0111,
      ACRB_TM_USER = 4'b1000,
      ACRB_TM_RAMP = 4'b1111
   } acrb_test_t;
endpackage : acrb_pkg
`default_nettype wire

// ### design/acrb_top.sv
// Shadowed ADC control registers with test-pattern output path
`timescale 1ns/1ps
`default_nettype none
// Function
// - Register writes land in shadow copies only
// - Writing 0x01 to 0xFF commits, self-clears
// - Power mode: normal, power-down, standby
// - Nonzero ratio forces stabilizer on
// - Phase field delays divided clock cycles
// - Nonzero pattern code replaces converted samples, except unused 1001-1110, which pass them
// - Codes off, midscale, plus and minus full
// - Code 0100 gives checkerboard
// - Codes 0101/0110 long/short pseudonoise
// - Code 0111 toggles all ones/zeros
// - Code 1000 sends user patterns
// - Unused codes avoided; 1111 ramps
// - Bit 7 repeats or single-shots user patterns
// - Signed six-bit offset added to converted samples, not to pattern words
module acrb_top (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic [acrb_pkg::OUT_W-1:0] adc_sample,
   input wire logic [acrb_pkg::PAT_W-1:0] user_pat [4],
   output logic [acrb_pkg::OUT_W-1:0] data_out,
   output logic [1:0] power_mode,
   output logic stabilizer_on,
   output logic div_clk_en
);
   import acrb_pkg::*;

   // ********************************************
   // Reset synchroniser
   // ********************************************
   logic rst_s1_r, rst_s2_r, rst_n;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // ********************************************
   // Shadow and active registers
   // ********************************************
   logic [7:0] sh_power_r, sh_stab_r, sh_div_r, sh_test_r, sh_off_r;
   logic [7:0] ac_power_r, ac_stab_r, ac_div_r, ac_test_r, ac_off_r;
   logic commit;
   assign commit = reg_wr && reg_addr == ADDR_COMMIT
                   && reg_wdata == COMMIT_VALUE;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_power_r <= RST_POWER;
         sh_stab_r <= RST_STAB;
         sh_div_r <= RST_CLKDIV;
         sh_test_r <= RST_TEST;
         sh_off_r <= RST_OFFSET;
      end else if (reg_wr) begin
         // Open bits are kept at zero so readback stays honest
         case (reg_addr)
            ADDR_POWER: sh_power_r <= {6'h00, reg_wdata[1:0]};
            ADDR_STAB: sh_stab_r <= {7'h00, reg_wdata[0]};
            ADDR_CLKDIV: sh_div_r <= {2'h0, reg_wdata[5:0]};
            ADDR_TEST: sh_test_r <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            ADDR_OFFSET: sh_off_r <= {2'h0, reg_wdata[5:0]};
            default: ;
         endcase
      end
   end

   // Restart bits act once per commit, then read back as written
   logic long_restart, short_restart;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ac_power_r <= RST_POWER;
         ac_stab_r <= RST_STAB;
         ac_div_r <= RST_CLKDIV;
         ac_test_r <= RST_TEST;
         ac_off_r <= RST_OFFSET;
      end else if (commit) begin
         ac_power_r <= sh_power_r;
         ac_stab_r <= sh_stab_r;
         ac_div_r <= sh_div_r;
         ac_test_r <= sh_test_r;
         ac_off_r <= sh_off_r;
      end
   end
   assign long_restart = commit && sh_test_r[LONG_RESTART_BIT];
   assign short_restart = commit && sh_test_r[SHORT_RESTART_BIT];

   // ********************************************
   // Register read
   // ********************************************
   // Transfer bit self-clears in the same cycle, so it always reads 0
   always_comb begin
      reg_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_RATE_BIN: reg_rdata = {2'h0, RATE_BIN_DEFAULT, 4'h0};
            ADDR_POWER: reg_rdata = sh_power_r;
            ADDR_STAB: reg_rdata = sh_stab_r;
            ADDR_CLKDIV: reg_rdata = sh_div_r;
            ADDR_TEST: reg_rdata = sh_test_r;
            ADDR_OFFSET: reg_rdata = sh_off_r;
            default: reg_rdata = 8'h00;
         endcase
      end
   end

   // ********************************************
   // Power, stabilizer, divider
   // ********************************************
   logic [2:0] div_ratio, div_phase;
   logic [2:0] div_cnt_r;
   logic [6:0] div_dly_r;
   assign div_ratio = ac_div_r[2:0];
   assign div_phase = ac_div_r[5:3];
   assign power_mode = ac_power_r[1:0];
   assign stabilizer_on = ac_stab_r[0] || div_ratio != 3'h0;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 3'h0;
      end else if (div_cnt_r >= div_ratio) begin
         div_cnt_r <= 3'h0;
      end else begin
         div_cnt_r <= div_cnt_r + 3'h1;
      end
   end

   // Tap line delays the divided tick by the phase code; code 7 uses the same tap as 6
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_dly_r <= 7'h00;
      end else begin
         div_dly_r <= {div_dly_r[5:0], div_cnt_r == 3'h0};
      end
   end
   assign div_clk_en = (div_phase == 3'h7) ? div_dly_r[6]
                       : div_dly_r[div_phase];

   // ********************************************
   // Pattern generators
   // ********************************************
   logic [22:0] pn_long_r;
   logic [8:0] pn_short_r;
   logic [OUT_W-1:0] ramp_r;
   logic toggle_r, user_done_r;
   logic [1:0] user_idx_r;
   logic tick;
   assign tick = sample_valid && ac_power_r[1:0] == ACRB_PWR_NORMAL;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pn_long_r <= LONG_SEED;
         pn_short_r <= SHORT_SEED;
      end else begin
         if (long_restart) begin
            pn_long_r <= LONG_SEED;
         end else if (tick) begin
            pn_long_r <= {pn_long_r[21:0], pn_long_r[22] ^ pn_long_r[17]};
         end
         if (short_restart) begin
            pn_short_r <= SHORT_SEED;
         end else if (tick) begin
            pn_short_r <= {pn_short_r[7:0], pn_short_r[8] ^ pn_short_r[4]};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_r <= '0;
         toggle_r <= 1'b0;
      end else if (tick) begin
         ramp_r <= ramp_r + 11'h001;
         toggle_r <= ~toggle_r;
      end
   end

   // User pattern walker restarts on each commit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         user_idx_r <= 2'h0;
         user_done_r <= 1'b0;
      end else if (commit) begin
         user_idx_r <= 2'h0;
         user_done_r <= 1'b0;
      end else if (tick && ac_test_r[3:0] == ACRB_TM_USER) begin
         user_idx_r <= user_idx_r + 2'h1;
         if (user_idx_r == 2'h3 && ac_test_r[TEST_SINGLE_BIT]) begin
            user_done_r <= 1'b1;
         end
      end
   end

   // ********************************************
   // Output selection
   // ********************************************
   logic [OUT_W-1:0] sel;
   logic [OUT_W:0] sum;
   logic [OUT_W-1:0] pat_word;
   assign pat_word = user_pat[user_idx_r][PAT_W-1:PAT_W-OUT_W];
   // Offset is sign-extended; wrap rather than clamp
   assign sum = {1'b0, adc_sample}
                + {{(OUT_W-5){ac_off_r[5]}}, ac_off_r[5:0]};

   always_comb begin
      case (ac_test_r[3:0])
         ACRB_TM_OFF: sel = sum[OUT_W-1:0];
         ACRB_TM_MID: sel = MIDSCALE;
         ACRB_TM_POS: sel = POS_FS;
         ACRB_TM_NEG: sel = NEG_FS;
         ACRB_TM_CHECK: sel = toggle_r ? ~CHECKER : CHECKER;
         ACRB_TM_PNL: sel = pn_long_r[OUT_W-1:0];
         ACRB_TM_PNS: sel = {pn_short_r, pn_short_r[8:7]};
         ACRB_TM_TOGGLE: sel = toggle_r ? '1 : '0;
         ACRB_TM_USER: sel = user_done_r ? '0 : pat_word;
         ACRB_TM_RAMP: sel = ramp_r;
         default: sel = sum[OUT_W-1:0];
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= '0;
      end else if (tick) begin
         data_out <= sel;
      end
   end

   // ********************************************
   // Checks
   // ********************************************
   sequence s_commit;
      commit;
   endsequence

   a_shadow_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_POWER && !commit |=> $stable(ac_power_r))
      else $error("active power changed without commit");
   a_commit_copy: assert property (@(posedge mclk) disable iff (!rst_n)
      s_commit |=> ac_test_r == $past(sh_test_r))
      else $error("commit did not copy pattern control");
   a_power_out: assert property (@(posedge mclk) disable iff (!rst_n)
      power_mode == ac_power_r[1:0])
      else $error("power mode output mismatch");
   a_div_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      div_cnt_r == div_ratio && $stable(div_ratio) |=> div_cnt_r == 3'h0)
      else $error("divider did not wrap");
   a_stab_force: assert property (@(posedge mclk) disable iff (!rst_n)
      div_ratio != 3'h0 |-> stabilizer_on)
      else $error("stabilizer not forced");
   a_test_pos: assert property (@(posedge mclk) disable iff (!rst_n)
      tick && ac_test_r[3:0] == ACRB_TM_POS |=> data_out == POS_FS)
      else $error("positive full scale wrong");
   a_toggle_flip: assert property (@(posedge mclk) disable iff (!rst_n)
      tick && ac_test_r[3:0] == ACRB_TM_TOGGLE ##1
      tick && ac_test_r[3:0] == ACRB_TM_TOGGLE
      |=> data_out == ~$past(data_out))
      else $error("toggle word did not flip");
   a_long_restart: assert property (@(posedge mclk) disable iff (!rst_n)
      long_restart |=> pn_long_r == LONG_SEED)
      else $error("long noise not restarted");
   a_offset_add: assert property (@(posedge mclk) disable iff (!rst_n)
      tick && ac_test_r[3:0] == ACRB_TM_OFF
      |=> data_out == $past(sum[OUT_W-1:0]))
      else $error("offset not applied");
endmodule : acrb_top
`default_nettype wire

// ### tb/acrb_host.sv
// Host model driving the register port of the control bank
`timescale 1ns/1ps
`default_nettype none
module acrb_host (
   input wire logic mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Idle lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #2;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge mclk);
      #2;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #2;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge mclk);
      d = reg_rdata;
      #2;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask : rd
   task automatic commit();
      wr(8'hFF, 8'h01);
   endtask : commit
endmodule : acrb_host
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the shadowed control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import acrb_pkg::*;
   logic mclk, rstn, sample_valid, stabilizer_on, div_clk_en;
   logic reg_wr, reg_rd;
   logic [OUT_W-1:0] adc_sample, data_out, v0, v1, v2, v3;
   logic [PAT_W-1:0] user_pat [4];
   logic [1:0] power_mode;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   int err_count, checks, n;
   int cyc, p0, pos;
   acrb_top uut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_valid(sample_valid), .adc_sample(adc_sample),
      .user_pat(user_pat), .data_out(data_out), .power_mode(power_mode),
      .stabilizer_on(stabilizer_on), .div_clk_en(div_clk_en));
   acrb_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   always #10 mclk = ~mclk;
   // Free-running cycle count gives the divider pulses a common time base
   always @(posedge mclk) cyc <= cyc + 1;
   task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rd);
      cmp({3'h0, rd}, {3'h0, e});
   endtask : rchk
   task automatic tick(input logic [10:0] s, output logic [10:0] q);
      @(posedge mclk);
      #2;
      adc_sample = s;
      sample_valid = 1'b1;
      @(posedge mclk);
      #2;
      sample_valid = 1'b0;
      adc_sample = ~s;
      q = data_out;
   endtask : tick
   // Two samples on back-to-back edges
   task automatic tick2(input logic [10:0] s, output logic [10:0] q0,
      output logic [10:0] q1);
      @(posedge mclk);
      #2;
      adc_sample = s;
      sample_valid = 1'b1;
      @(posedge mclk);
      #2;
      q0 = data_out;
      @(posedge mclk);
      #2;
      sample_valid = 1'b0;
      adc_sample = ~s;
      q1 = data_out;
   endtask : tick2
   task automatic setreg(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      host.commit();
   endtask : setreg
   task automatic divcnt(input logic [7:0] v, input int e);
      setreg(ADDR_CLKDIV, v);
      repeat (16) @(posedge mclk);
      n = 0;
      repeat (64) begin
         @(posedge mclk);
         #1;
         if (div_clk_en === 1'b1) begin
            n++;
            pos = cyc % 8;
         end
      end
      cmp(n[10:0], e[10:0]);
   endtask : divcnt
   task automatic complete_run();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
   initial begin
      mclk = 1'b0;
      rstn = 1'b0;
      sample_valid = 1'b0;
      adc_sample = 11'h000;
      err_count = 0;
      checks = 0;
      cyc = 0;
      p0 = 0;
      pos = 0;
      for (int i = 0; i < 4; i++) user_pat[i] = 16'h1000 * (i + 1) + 16'h0020;
      repeat (2) @(posedge mclk);
      #2;
      rstn = 1'b1;
      repeat (3) @(posedge mclk);
      // ******** Reset values ********
      rchk(ADDR_POWER, 8'h00);
      rchk(ADDR_STAB, 8'h01);
      rchk(ADDR_CLKDIV, 8'h00);
      rchk(ADDR_TEST, 8'h00);
      rchk(ADDR_OFFSET, 8'h00);
      rchk(ADDR_COMMIT, 8'h00);
      rchk(ADDR_RATE_BIN, {2'h0, RATE_BIN_DEFAULT, 4'h0});
      cmp({10'h0, stabilizer_on}, 11'h001);
      $display("test reset done");
      // ******** Shadow then commit ********
      host.wr(ADDR_POWER, 8'hFD);
      rchk(ADDR_POWER, 8'h01);
      cmp({9'h0, power_mode}, 11'h000);
      host.commit();
      cmp({9'h0, power_mode}, 11'h001);
      rchk(ADDR_COMMIT, 8'h00);
      setreg(ADDR_POWER, 8'h02);
      cmp({9'h0, power_mode}, 11'h002);
      setreg(ADDR_POWER, 8'h00);
      cmp({9'h0, power_mode}, 11'h000);
      $display("test commit done");
      // ******** Divider and stabilizer ********
      setreg(ADDR_STAB, 8'h00);
      divcnt(8'h00, 64);
      cmp({10'h0, stabilizer_on}, 11'h000);
      divcnt(8'h03, 16);
      cmp({10'h0, stabilizer_on}, 11'h001);
      divcnt(8'h07, 8);
      // Same ratio keeps the counter running, so only the phase moves
      p0 = pos;
      divcnt(8'h2F, 8);
      cmp(11'((pos - p0 + 8) % 8), 11'h005);
      divcnt(8'h2B, 16);
      divcnt(8'h00, 64);
      $display("test divider done");
      // ******** Fixed test words ********
      setreg(ADDR_TEST, 8'h01);
      tick(11'h123, v0);
      cmp(v0, MIDSCALE);
      setreg(ADDR_TEST, 8'h02);
      tick(11'h123, v0);
      cmp(v0, POS_FS);
      setreg(ADDR_TEST, 8'h03);
      tick(11'h123, v0);
      cmp(v0, NEG_FS);
      setreg(ADDR_TEST, 8'h04);
      tick(11'h123, v0);
      tick(11'h123, v1);
      cmp(v1, ~v0);
      cmp({10'h0, (v0 === CHECKER || v0 === ~CHECKER)}, 11'h001);
      setreg(ADDR_TEST, 8'h07);
      tick(11'h123, v0);
      tick(11'h123, v1);
      cmp(v1, ~v0);
      cmp({10'h0, (v0 === 11'h7FF || v0 === 11'h000)}, 11'h001);
      tick2(11'h123, v0, v1);
      cmp(v1, ~v0);
      setreg(ADDR_TEST, 8'h0F);
      tick(11'h123, v0);
      tick(11'h123, v1);
      cmp(v1, v0 + 11'h001);
      $display("test words done");
      // ******** Noise restart replays the same words ********
      for (int k = 0; k < 2; k++) begin
         setreg(ADDR_TEST, k == 0 ? 8'h25 : 8'h16);
         tick(11'h0, v0);
         tick(11'h0, v1);
         tick(11'h0, v2);
         cmp({10'h0, v1 !== v0}, 11'h001);
         setreg(ADDR_TEST, k == 0 ? 8'h25 : 8'h16);
         tick(11'h0, v3);
         cmp(v3, v0);
         tick(11'h0, v3);
         cmp(v3, v1);
         tick(11'h0, v3);
         cmp(v3, v2);
      end
      $display("test noise done");
      // ******** User patterns, repeat then single ********
      for (int k = 0; k < 2; k++) begin
         setreg(ADDR_TEST, k == 0 ? 8'h08 : 8'h88);
         for (int i = 0; i < 5; i++) begin
            tick(11'h0, v0);
            v1 = (i == 4) ? (k == 0 ? user_pat[0][15:5] : 11'h000)
               : user_pat[i][15:5];
            cmp(v0, v1);
         end
      end
      $display("test user done");
      // ******** Offset on normal data ********
      setreg(ADDR_TEST, 8'h00);
      setreg(ADDR_OFFSET, 8'h3F);
      tick(11'h100, v0);
      cmp(v0, 11'h0FF);
      setreg(ADDR_OFFSET, 8'h1F);
      tick(11'h100, v0);
      cmp(v0, 11'h11F);
      $display("test offset done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
